// file: src/scrp_pkg.sv
// Package of constants and carrier types for the streaming config receive port.
package scrp_pkg;
  // Bus width encodings on the scheme_select straps.
  localparam logic [2:0] SEL_X32 = 3'h0;
  localparam logic [2:0] SEL_X16 = 3'h5;
  localparam logic [2:0] SEL_X8 = 3'h6;
  // Longest words the link may still deliver after ready drops.
  localparam int unsigned SKID_WORDS = 6;
  localparam logic [3:0] SKID_DEPTH = 4'h6;
  // Main cycles that the link clock counts as running after its last sign.
  localparam logic [3:0] LIVE_CYCLES = 4'h8;
  // Reset values.
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  // Main-domain states.
  typedef enum logic [2:0] {
    SCRP_IDLE = 3'b000,
    SCRP_CLEAR = 3'b001,
    SCRP_WAIT = 3'b010,
    SCRP_LOAD = 3'b011,
    SCRP_DONE = 3'b100
  } scrp_state_t;
  // One accepted word with its lane count.
  typedef struct packed {
    logic [31:0] data;
    logic [2:0] width;
  } scrp_word_t;
endpackage

// file: src/scrp_sync3.sv
// Three-flop level synchroniser with agreement of the last two stages.
`timescale 1ns/1ps
module scrp_sync3 (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Level in and filtered level out.
  input wire logic d_i,
  output logic q_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } scrp_sync_t;
  scrp_sync_t r;
  scrp_sync_t next_r;

  // Stage one feeds only stage two; the output moves when two and three agree.
  always_comb begin
    next_r = r;
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    if (r.s2 == r.s3) begin
      next_r.q = r.s3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r.q;
endmodule

// file: src/scrp_top.sv
// Device side of the streaming configuration receive port.
`timescale 1ns/1ps
module scrp_top #(
  parameter int unsigned LOAD_BYTES = 64,
  parameter int unsigned PAUSE_EVERY = 16,
  parameter int unsigned PAUSE_LEN = 8
) (
  // Main clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Link clock from the host.
  input wire logic link_clk_i,
  // Configuration request and status pins.
  input wire logic config_request_n_i,
  output logic status_ok_n_o,
  output logic load_complete_o,
  input wire logic [2:0] scheme_select_i,
  // Stream data.
  input wire logic [31:0] cfg_data_i,
  input wire logic cfg_valid_i,
  output logic cfg_ready_o,
  output logic narrow_cfg_ready_o,
  // Word handed to the configuration core.
  output logic [31:0] word_data_o,
  output logic word_strobe_o,
  output logic wide_pins_user_o
);
  // The counters are 16 bits wide, so each count must fit there.
  if (PAUSE_LEN == 0 || PAUSE_EVERY == 0 || LOAD_BYTES == 0 ||
      PAUSE_LEN > 65535 || PAUSE_EVERY > 65535 ||
      LOAD_BYTES > 65535) begin : g_bad_counts
    $error("scrp_top: counts must lie between 1 and 65535");
  end

  ////////////////////////////////////////////////////////////////////////
  // Main domain: synchronise pins, link activity and the write pointer.
  logic req_n_s;
  logic act_s;
  logic link_act;
  logic [2:0] strap_s;
  logic [3:0] wg_s;
  logic [3:0] rd_gray;
  scrp_pkg::scrp_word_t link_word;

  scrp_sync3 u_req (.clk_i(mclk_i), .rst_i(rst_i),
    .d_i(config_request_n_i), .q_o(req_n_s));
  scrp_sync3 u_act (.clk_i(mclk_i), .rst_i(rst_i),
    .d_i(link_act), .q_o(act_s));

  // The straps are pins as well, so they pass the same filter.
  for (genvar i = 0; i < 3; i++) begin : g_strap
    scrp_sync3 u_strap (.clk_i(mclk_i), .rst_i(rst_i),
      .d_i(scheme_select_i[i]), .q_o(strap_s[i]));
  end

  typedef struct packed {
    scrp_pkg::scrp_state_t st;
    logic [2:0] width;
    logic [3:0] rp;
    logic act_seen;
    logic [3:0] live;
    logic [15:0] bytes;
    logic [15:0] since;
    logic [15:0] pause;
    logic ready;
    logic [31:0] word;
    logic strobe;
  } scrp_main_t;
  scrp_main_t m;
  scrp_main_t next_m;
  logic [2:0] strap_w;

  // Strap decode of lane count; unknown codes fall back to x8.
  always_comb begin
    case (strap_s)
      scrp_pkg::SEL_X32: strap_w = 3'h4;
      scrp_pkg::SEL_X16: strap_w = 3'h2;
      default: strap_w = 3'h1;
    endcase
  end

  // Gray form of the read pointer, compared with the filtered write side.
  assign rd_gray = m.rp ^ (m.rp >> 1);

  // Sequencer: clear on request low, wait, load, done.
  always_comb begin
    next_m = m;
    next_m.strobe = 1'b0;
    // A stopped link clock freezes the activity bit, so the count runs out.
    next_m.act_seen = act_s;
    if (act_s != m.act_seen) begin
      next_m.live = scrp_pkg::LIVE_CYCLES;
    end else if (m.live != 4'h0) begin
      next_m.live = m.live - 4'h1;
    end
    // The buffer drains in every state; only a load counts the words.
    if (rd_gray != wg_s) begin
      next_m.rp = m.rp + 4'h1;
    end
    if (!req_n_s) begin
      next_m.st = scrp_pkg::SCRP_CLEAR;
      next_m.bytes = scrp_pkg::CNT_RST;
      next_m.since = scrp_pkg::CNT_RST;
      next_m.pause = scrp_pkg::CNT_RST;
      next_m.ready = 1'b0;
      next_m.width = strap_w;
    end else begin
      case (m.st)
        scrp_pkg::SCRP_IDLE: next_m.st = scrp_pkg::SCRP_IDLE;
        scrp_pkg::SCRP_CLEAR: next_m.st = scrp_pkg::SCRP_WAIT;
        scrp_pkg::SCRP_WAIT: begin
          next_m.st = scrp_pkg::SCRP_LOAD;
          next_m.ready = 1'b1;
        end
        scrp_pkg::SCRP_LOAD: begin
          if (m.pause != scrp_pkg::CNT_RST) begin
            next_m.pause = m.pause - 16'h0001;
            next_m.ready = (m.pause == 16'h0001);
          end
          if (rd_gray != wg_s) begin
            next_m.word = link_word.data;
            next_m.strobe = 1'b1;
            next_m.bytes = m.bytes + 16'(m.width);
            next_m.since = m.since + 16'h0001;
            if (16'(m.bytes + 16'(m.width)) >= 16'(LOAD_BYTES)) begin
              next_m.st = scrp_pkg::SCRP_DONE;
              next_m.ready = 1'b0;
            end else if (m.since + 16'h0001 >= 16'(PAUSE_EVERY)) begin
              next_m.since = scrp_pkg::CNT_RST;
              next_m.pause = 16'(PAUSE_LEN); // Decompression stall.
              next_m.ready = 1'b0;
            end
          end
        end
        scrp_pkg::SCRP_DONE: next_m.st = scrp_pkg::SCRP_DONE;
        default: next_m.st = scrp_pkg::SCRP_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      m <= '0;
    end else begin
      m <= next_m;
    end
  end

  // Ready also needs the link clock seen running.
  assign cfg_ready_o = m.ready && (m.live != 4'h0) &&
    (m.width != 3'h1);
  assign narrow_cfg_ready_o = m.ready && (m.live != 4'h0) &&
    (m.width == 3'h1);
  assign status_ok_n_o = (m.st == scrp_pkg::SCRP_CLEAR) ||
    (m.st == scrp_pkg::SCRP_IDLE);
  assign load_complete_o = (m.st == scrp_pkg::SCRP_DONE);
  assign wide_pins_user_o = load_complete_o && (m.width != 3'h1);
  assign word_data_o = m.word;
  assign word_strobe_o = m.strobe;

  ////////////////////////////////////////////////////////////////////////
  // Link domain: capture words and report clock activity.
  logic ready_l;
  logic rdy_raw;
  assign rdy_raw = m.ready;
  scrp_sync3 u_rdy (.clk_i(link_clk_i), .rst_i(rst_i),
    .d_i(rdy_raw), .q_o(ready_l));

  typedef struct packed {
    scrp_pkg::scrp_word_t [7:0] mem;
    logic [3:0] wp;
    logic [3:0] wg;
    logic [1:0] act;
    logic [2:0] skid;
  } scrp_link_t;
  scrp_link_t l;
  scrp_link_t next_l;
  logic [2:0] w_l;
  logic [3:0] next_wp;
  assign w_l = m.width; // Static after clear while the link runs.

  // Words land in an eight-slot buffer, since the link may deliver one
  // per link cycle, faster than a toggle could cross. The main side
  // drains a word per cycle, so at most four slots are ever in use.
  // Up to six words are still taken after ready drops.
  always_comb begin
    next_l = l;
    next_l.act = l.act + 2'h1;
    next_wp = l.wp + 4'h1;
    if (ready_l) begin
      next_l.skid = 3'h0;
    end
    if (cfg_valid_i && (ready_l || l.skid < scrp_pkg::SKID_DEPTH[2:0])) begin
      next_l.mem[l.wp[2:0]].data = cfg_data_i;
      next_l.mem[l.wp[2:0]].width = w_l;
      next_l.wp = next_wp;
      next_l.wg = next_wp ^ (next_wp >> 1);
      if (!ready_l) begin
        next_l.skid = l.skid + 3'h1;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (rst_i) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // Quarter rate, each level held for two link cycles, so every level outlasts the agreement filter.
  assign link_act = l.act[1];
  // A slot stands still for eight link words after the pointer moves.
  assign link_word = l.mem[m.rp[2:0]];

  // Gray write pointer: one bit moves per word, so the filtered copy is
  // always a pointer value that the link really held.
  for (genvar i = 0; i < 4; i++) begin : g_wptr
    scrp_sync3 u_wptr (.clk_i(mclk_i), .rst_i(rst_i),
      .d_i(l.wg[i]), .q_o(wg_s[i]));
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  a_done_no_ready: assert property (@(posedge mclk_i) disable iff (rst_i)
    load_complete_o |-> !cfg_ready_o && !narrow_cfg_ready_o)
    else $error("ready while load complete");
  a_clear_on_req: assert property (@(posedge mclk_i) disable iff (rst_i)
    !req_n_s |=> m.st == scrp_pkg::SCRP_CLEAR && !m.ready)
    else $error("request low did not clear");
  a_status_ready: assert property (@(posedge mclk_i) disable iff (rst_i)
    status_ok_n_o |-> !m.ready)
    else $error("ready while status low");
  a_ready_act: assert property (@(posedge mclk_i) disable iff (rst_i)
    cfg_ready_o || narrow_cfg_ready_o |-> m.live != 4'h0)
    else $error("ready without link activity");
  a_pause_len: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(m.ready) && m.st == scrp_pkg::SCRP_LOAD |=> !m.ready[*7])
    else $error("pause too short");
  a_no_take: assert property (@(posedge link_clk_i) disable iff (rst_i)
    !cfg_valid_i |=> $stable(l.wp))
    else $error("word taken without valid");
  a_skid_max: assert property (@(posedge link_clk_i) disable iff (rst_i)
    l.skid <= 3'h6)
    else $error("skid over six words");
  a_take_valid: assert property (@(posedge link_clk_i) disable iff (rst_i)
    cfg_valid_i && ready_l |=> l.wp != $past(l.wp))
    else $error("valid word not taken");
  c_load: cover property (@(posedge mclk_i) disable iff (rst_i)
    $rose(load_complete_o));
  c_pause: cover property (@(posedge mclk_i) disable iff (rst_i)
    m.st == scrp_pkg::SCRP_LOAD && $fell(m.ready));
  c_skid: cover property (@(posedge link_clk_i) disable iff (rst_i)
    l.skid == 3'h6);
endmodule

// file: tb/scrp_host_model.sv
// Behavioural model of the host that streams the bitstream into the port.
`timescale 1ns/1ps
module scrp_host_model (
  // Link clock and reset.
  input wire logic link_clk_i,
  input wire logic rst_i,
  // Device status and raw ready.
  input wire logic ready_i,
  input wire logic status_ok_n_i,
  // Pacing, file key, lanes per word and file length in bytes.
  input wire logic go_i,
  input wire logic [7:0] key_i,
  input wire logic [2:0] lanes_i,
  input wire logic [15:0] len_i,
  // Stream towards the device.
  output logic [31:0] data_o,
  output logic valid_o
);
  logic r1;
  logic r2;
  logic [15:0] nb;
  // Ready is async to the link clock, so two flops tame it first.
  always_ff @(posedge link_clk_i) begin
    if (rst_i) begin
      r1 <= 1'h0;
      r2 <= 1'h0;
    end else begin
      r1 <= ready_i;
      r2 <= r1;
    end
  end
  // Words leave only on synced ready; lanes beyond the width carry junk.
  always_ff @(posedge link_clk_i) begin
    if (rst_i) begin
      valid_o <= 1'h0; // Quiet until the device is up.
      nb <= 16'h0000;
      data_o <= 32'h0000_0000;
    end else if (go_i && r2 && !status_ok_n_i && nb < len_i) begin
      valid_o <= 1'h1;
      for (int i = 0; i < 4; i++) begin
        data_o[8*i+:8] <= key_i ^ 8'(nb + 16'(i));
      end
      nb <= nb + 16'(lanes_i);
    end else begin
      valid_o <= 1'h0;
      data_o <= ~data_o; // Released lines keep changing, never stale.
    end
  end
endmodule

// file: tb/testbench.sv
// Self-checking bench for the streaming config receive port.
`timescale 1ns/1ps
module testbench;
  logic mclk_i = 0, lclk = 0, lrun = 1, rst_i = 1, req_n = 1, go = 0;
  logic [2:0] sel = 3'h0;
  logic [2:0] lanes = 3'h4;
  logic [7:0] key = 8'h00;
  logic [31:0] data, wd, mask;
  logic valid, st_n, done, rdy, nrdy, strb, user;
  logic [31:0] q[$];
  logic [2:0] sels [3] = '{scrp_pkg::SEL_X8, scrp_pkg::SEL_X16,
    scrp_pkg::SEL_X32};
  int n_mismatch = 0, n_tests = 0, nw = 0;
  // Clocks; the link clock parks low whenever it is stopped.
  always #50 mclk_i = ~mclk_i;
  always #80 if (lrun || lclk) lclk = ~lclk;
  assign mask = lanes == 3'h1 ? 32'h0000_00ff :
    lanes == 3'h2 ? 32'h0000_ffff : 32'hffff_ffff;
  scrp_top #(.LOAD_BYTES(64), .PAUSE_EVERY(4), .PAUSE_LEN(8)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .link_clk_i(lclk),
    .config_request_n_i(req_n), .status_ok_n_o(st_n),
    .load_complete_o(done), .scheme_select_i(sel), .cfg_data_i(data),
    .cfg_valid_i(valid), .cfg_ready_o(rdy), .narrow_cfg_ready_o(nrdy),
    .word_data_o(wd), .word_strobe_o(strb), .wide_pins_user_o(user));
  scrp_host_model host (.link_clk_i(lclk), .rst_i(rst_i),
    .ready_i(lanes == 3'h1 ? nrdy : rdy), .status_ok_n_i(st_n),
    .go_i(go), .key_i(key), .lanes_i(lanes), .len_i(16'h0040),
    .data_o(data), .valid_o(valid));
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Host pacing is random so ready and valid meet in every phase.
  always @(posedge mclk_i) go <= ($urandom % 4) != 0;
  // Each word presented at a link edge is noted as expected.
  always @(posedge lclk) if (valid === 1'h1 && !rst_i) q.push_back(data);
  // Every strobe retires the oldest note.
  always @(posedge mclk_i) begin
    if (strb === 1'h1) begin
      nw++;
      check("word", wd & mask, q.size() ? q.pop_front() & mask : ~wd);
    end
  end
  // Main sequence: one full load per bus width.
  initial begin
    void'($urandom(19));
    for (int m = 0; m < 3; m++) begin
      @(posedge mclk_i);
      sel <= sels[m];
      lanes <= 3'(1 << m);
      key <= 8'($urandom);
      rst_i <= 1'h1;
      lrun = 1'h1;
      repeat (10) @(posedge mclk_i);
      rst_i <= 1'h0;
      req_n <= 1'h0;
      lrun = 1'h0;
      nw = 0;
      repeat (8) @(posedge mclk_i);
      check("status in clear", 32'(st_n), 32'h1);
      req_n <= 1'h1;
      for (int i = 0; i < 50 && st_n !== 1'h0; i++) @(posedge mclk_i);
      check("status ok", 32'(st_n), 32'h0);
      repeat (20) @(posedge mclk_i);
      check("ready clock stopped", 32'(rdy | nrdy), 32'h0);
      lrun = 1'h1; // Link clock runs without pause until complete.
      for (int i = 0; i < 20000 && done !== 1'h1; i++) @(posedge mclk_i);
      check("load complete", 32'(done), 32'h1);
      check("ready after load", 32'(rdy | nrdy), 32'h0);
      lrun = 1'h0;
      repeat (40) @(posedge mclk_i);
      check("complete holds", 32'(done), 32'h1);
      check("user pins", 32'(user), 32'(m != 0));
      check("word count", 32'(nw), 32'(64 >> m));
      check("words left", 32'(q.size()), 32'h0);
    end
    end_of_test();
  end
  // Watchdog well beyond three loads at the slowest pacing.
  initial begin
    #5_000_000;
    n_mismatch++;
    end_of_test();
  end
endmodule
